// file: common/fmw_pkg.sv
package fmw_pkg;
	// Wake pins handled by the block
	localparam int PIN_N = 8;
	// Pins 6 and 7 are output-only and may take no wake role
	localparam logic [7:0] PIN_WAKE_CAPABLE = 8'h3F;

	localparam int CLK_PERIOD_NS = 40;
	// Least time a wake input must stay steady before it is believed
	localparam int DEB_TIME_NS = 100000;
	localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEB_W = 12;
	localparam logic [11:0] DEB_LAST = 12'(DEB_CYC - 1);

	localparam int COUNT_W = 16;
	localparam int SRAM_AW = 4;
	localparam int SRAM_DW = 32;
	localparam int SRAM_DEPTH = 16;

	// Byte addresses on the register bus
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_ROLE = 8'h08;
	localparam logic [7:0] ADDR_HOLD = 8'h0C;
	localparam logic [7:0] ADDR_COUNT = 8'h10;
	localparam logic [7:0] ADDR_SRAM_ADDR = 8'h14;
	localparam logic [7:0] ADDR_SRAM_DATA = 8'h18;

	localparam int CTRL_ENTRY_BIT = 0;
	localparam int CTRL_SUSPEND_BIT = 1;
	localparam int STAT_FROZEN_BIT = 0;
	localparam int STAT_MATCH_BIT = 1;
	localparam int STAT_LEVEL_LSB = 8;

	// Wake role codes, two bits per pin
	localparam logic [1:0] ROLE_NONE = 2'h0;
	localparam logic [1:0] ROLE_EDGE = 2'h1;
	localparam logic [1:0] ROLE_HIGH = 2'h2;
	localparam logic [1:0] ROLE_LOW = 2'h3;

	localparam logic [15:0] ROLE_RST = 16'h0000;
	localparam logic [7:0] HOLD_RST = 8'h00;
	localparam logic SUSPEND_RST = 1'b1;

	typedef enum logic [0:0] {
		FMW_ACTIVE = 1'b0,
		FMW_FROZEN = 1'b1
	} fmw_state_t;
endpackage

// file: core/fmw_sram.sv
`timescale 1ns/1ns
module fmw_sram (
	input  wire logic                               i_clk,
	input  wire logic                               i_rst,
	input  wire logic                               i_we,
	input  wire logic [fmw_pkg::SRAM_AW-1:0]        i_addr,
	input  wire logic [fmw_pkg::SRAM_DW-1:0]        i_wdata,
	input  wire logic                               i_clear,
	output logic      [fmw_pkg::SRAM_DW-1:0]        o_rdata
);
	logic [fmw_pkg::SRAM_DW-1:0]    mem [0:fmw_pkg::SRAM_DEPTH-1];
	logic [fmw_pkg::SRAM_DEPTH-1:0] valid;

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end

	// Sleep loses contents; a write in the same cycle survives the clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			valid <= '0;
		end else begin
			if (i_clear) begin
				valid <= '0;
			end
			if (i_we) begin
				valid[i_addr] <= 1'b1;
			end
		end
	end

	assign o_rdata = valid[i_addr] ? mem[i_addr] : '0;

	property p_retain;
		@(posedge i_clk) disable iff (i_rst)
		(!i_we && !i_clear && valid[i_addr]) |=> (o_rdata == $past(o_rdata)) || $changed(i_addr);
	endproperty
	a_retain: assert property (p_retain) else $error("stored word changed without write"); // RQ10
endmodule // fmw_sram

// file: core/fmw_ctrl.sv
// Functional notes
// RQ1: Entry request halts all fabric activity
// RQ2: Any-edge pin wakes on either transition
// RQ3: Each pin has its own wake role
// RQ4: Signature members need high or low each
// RQ5: Signature wakes only when all members match
// RQ6: Complete signature present ends freeze at once
// RQ7: Matching signature keeps device active; refuse entry
// RQ8: Fabric logic resumes from retained state
// RQ9: Suspend setting keeps SRAM contents across freeze
// RQ10: Read after wake equals data written before
// RQ11: Idle pins tristate or hold during freeze
// RQ12: Output-only pins take no wake role
// RQ13: Wake inputs synchronised and debounced first
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
module fmw_ctrl (
	input  wire logic                              i_clk,
	input  wire logic                              i_rst,
	input  wire logic [7:0]                        i_avs_address,
	input  wire logic                              i_avs_read,
	input  wire logic                              i_avs_write,
	input  wire logic [31:0]                       i_avs_writedata,
	input  wire logic [3:0]                        i_avs_byteenable,
	output logic      [31:0]                       o_avs_readdata,
	output logic                                   o_avs_waitrequest,
	input  wire logic [fmw_pkg::PIN_N-1:0]         i_wake_pin,
	input  wire logic                              i_freeze_entry_request,
	input  wire logic [fmw_pkg::PIN_N-1:0]         i_fab_out,
	input  wire logic [fmw_pkg::PIN_N-1:0]         i_fab_oe,
	output logic      [fmw_pkg::PIN_N-1:0]         o_pin_out,
	output logic      [fmw_pkg::PIN_N-1:0]         o_pin_oe,
	output logic                                   o_frozen,
	output logic      [fmw_pkg::COUNT_W-1:0]       o_count
);
	localparam int NIN = fmw_pkg::PIN_N + 1;

	fmw_pkg::fmw_state_t            state;
	logic [NIN-1:0]                 sync1;
	logic [NIN-1:0]                 sync2;
	logic [NIN-1:0]                 deb;
	logic [fmw_pkg::DEB_W-1:0]      deb_cnt [0:NIN-1];
	logic                           entry_prev;
	logic [fmw_pkg::PIN_N-1:0]      snap;
	logic [fmw_pkg::PIN_N-1:0]      held_out;
	logic [fmw_pkg::PIN_N-1:0]      held_oe;
	logic [2*fmw_pkg::PIN_N-1:0]    role;
	logic [fmw_pkg::PIN_N-1:0]      hold;
	logic                           suspend;
	logic [fmw_pkg::SRAM_AW-1:0]    sram_addr;
	logic [fmw_pkg::SRAM_DW-1:0]    sram_rdata;
	logic                           ack;
	logic [31:0]                    rd_mux;
	logic [fmw_pkg::PIN_N-1:0]      lvl;
	logic [fmw_pkg::PIN_N-1:0]      edge_m;
	logic [fmw_pkg::PIN_N-1:0]      hi_m;
	logic [fmw_pkg::PIN_N-1:0]      lo_m;
	logic [fmw_pkg::COUNT_W-1:0]    count_inc;
	logic                           req;
	logic                           wr_go;
	logic                           bus_entry;
	logic                           entry_req;
	logic                           edge_hit;
	logic                           sig_match;
	logic                           wake;
	logic                           frozen;
	logic                           sram_we;
	logic                           sram_clear;

	// Pins matching one role code
	function automatic logic [fmw_pkg::PIN_N-1:0] fmw_role_mask(
		input logic [2*fmw_pkg::PIN_N-1:0] roles,
		input logic [1:0]                  code
	);
		logic [fmw_pkg::PIN_N-1:0] m;
		m = '0;
		for (int k = 0; k < fmw_pkg::PIN_N; k++) begin
			m[k] = (roles[2*k +: 2] == code);
		end
		return m;
	endfunction

	// Forces the role of every output-only pin to none
	function automatic logic [2*fmw_pkg::PIN_N-1:0] fmw_role_filter(
		input logic [2*fmw_pkg::PIN_N-1:0] roles
	);
		logic [2*fmw_pkg::PIN_N-1:0] r;
		r = roles;
		for (int k = 0; k < fmw_pkg::PIN_N; k++) begin
			if (!fmw_pkg::PIN_WAKE_CAPABLE[k]) begin
				r[2*k +: 2] = fmw_pkg::ROLE_NONE;
			end
		end
		return r;
	endfunction

	// Byte-lane merge of a bus write into a register
	function automatic logic [31:0] fmw_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	// RQ13 two-stage synchroniser
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= {i_freeze_entry_request, i_wake_pin};
			sync2 <= sync1;
		end
	end

	// RQ13 debounce each input
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			deb <= '0;
			for (int i = 0; i < NIN; i++) begin
				deb_cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NIN; i++) begin
				if (sync2[i] == deb[i]) begin
					deb_cnt[i] <= '0;
				end else if (deb_cnt[i] == fmw_pkg::DEB_LAST) begin
					deb[i] <= sync2[i];
					deb_cnt[i] <= '0;
				end else begin
					deb_cnt[i] <= deb_cnt[i] + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			entry_prev <= 1'b0;
		end else begin
			entry_prev <= deb[fmw_pkg::PIN_N];
		end
	end

	assign lvl = deb[fmw_pkg::PIN_N-1:0];
	assign frozen = (state == fmw_pkg::FMW_FROZEN);

	// RQ3 per-pin role decode
	assign edge_m = fmw_role_mask(role, fmw_pkg::ROLE_EDGE);
	assign hi_m = fmw_role_mask(role, fmw_pkg::ROLE_HIGH);
	assign lo_m = fmw_role_mask(role, fmw_pkg::ROLE_LOW);

	// RQ2 level differs from that at entry
	assign edge_hit = |(edge_m & (lvl ^ snap));

	// RQ4 RQ5 AND of all signature members
	assign sig_match = (|(hi_m | lo_m)) && (&((~hi_m | lvl) & (~lo_m | ~lvl)));

	assign wake = edge_hit | sig_match;

	// Avalon slave: one wait cycle on every access
	assign req = i_avs_read | i_avs_write;
	assign o_avs_waitrequest = req & ~ack;
	assign wr_go = i_avs_write & ack;
	assign bus_entry = wr_go && (i_avs_address == fmw_pkg::ADDR_CTRL) && i_avs_byteenable[0]
		&& i_avs_writedata[fmw_pkg::CTRL_ENTRY_BIT];
	assign entry_req = bus_entry | (deb[fmw_pkg::PIN_N] & ~entry_prev);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	always_comb begin
		rd_mux = '0;
		case (i_avs_address)
			fmw_pkg::ADDR_CTRL: begin
				rd_mux[fmw_pkg::CTRL_SUSPEND_BIT] = suspend;
			end
			fmw_pkg::ADDR_STATUS: begin
				rd_mux[fmw_pkg::STAT_FROZEN_BIT] = frozen;
				rd_mux[fmw_pkg::STAT_MATCH_BIT] = sig_match;
				rd_mux[fmw_pkg::STAT_LEVEL_LSB +: fmw_pkg::PIN_N] = lvl;
			end
			fmw_pkg::ADDR_ROLE: begin
				rd_mux[2*fmw_pkg::PIN_N-1:0] = role;
			end
			fmw_pkg::ADDR_HOLD: begin
				rd_mux[fmw_pkg::PIN_N-1:0] = hold;
			end
			fmw_pkg::ADDR_COUNT: begin
				rd_mux[fmw_pkg::COUNT_W-1:0] = o_count;
			end
			fmw_pkg::ADDR_SRAM_ADDR: begin
				rd_mux[fmw_pkg::SRAM_AW-1:0] = sram_addr;
			end
			fmw_pkg::ADDR_SRAM_DATA: begin
				rd_mux = frozen ? '0 : sram_rdata;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_avs_readdata <= '0;
		end else if (i_avs_read && !ack) begin
			o_avs_readdata <= rd_mux;
		end
	end

	// Configuration registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			role <= fmw_pkg::ROLE_RST;
			hold <= fmw_pkg::HOLD_RST;
			suspend <= fmw_pkg::SUSPEND_RST;
			sram_addr <= '0;
		end else if (wr_go) begin
			case (i_avs_address)
				fmw_pkg::ADDR_CTRL: begin
					if (i_avs_byteenable[0]) begin
						suspend <= i_avs_writedata[fmw_pkg::CTRL_SUSPEND_BIT];
					end
				end
				fmw_pkg::ADDR_ROLE: begin
					// RQ12 no role on output-only pins
					role <= fmw_role_filter(16'(fmw_merge({16'h0000, role}, i_avs_writedata,
						i_avs_byteenable)));
				end
				fmw_pkg::ADDR_HOLD: begin
					hold <= 8'(fmw_merge({24'h000000, hold}, i_avs_writedata,
						i_avs_byteenable));
				end
				fmw_pkg::ADDR_SRAM_ADDR: begin
					sram_addr <= 4'(fmw_merge({28'h0000000, sram_addr}, i_avs_writedata,
						i_avs_byteenable));
				end
				default: begin
				end
			endcase
		end
	end

	// Freeze state machine
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= fmw_pkg::FMW_ACTIVE;
		end else begin
			case (state)
				fmw_pkg::FMW_ACTIVE: begin
					// RQ7 entry refused while signature holds
					if (entry_req && !sig_match) begin
						state <= fmw_pkg::FMW_FROZEN;
					end
				end
				fmw_pkg::FMW_FROZEN: begin
					// RQ6 leave as soon as wake condition seen
					if (wake) begin
						state <= fmw_pkg::FMW_ACTIVE;
					end
				end
				default: begin
					state <= fmw_pkg::FMW_ACTIVE;
				end
			endcase
		end
	end

	// Pin levels and fabric drive tracked until entry
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			snap <= '0;
			held_out <= '0;
			held_oe <= '0;
		end else if (!frozen) begin
			snap <= lvl;
			held_out <= i_fab_out;
			held_oe <= i_fab_oe;
		end
	end

	// RQ11 tristate or hold while frozen
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pin_out <= '0;
			o_pin_oe <= '0;
		end else if (frozen) begin
			o_pin_out <= held_out & hold;
			o_pin_oe <= held_oe & hold;
		end else begin
			o_pin_out <= i_fab_out;
			o_pin_oe <= i_fab_oe;
		end
	end

	// RQ1 RQ8 fabric counter halts and resumes
	assign count_inc = o_count + 1'b1;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_count <= '0;
		end else if (!frozen) begin
			o_count <= count_inc;
		end
	end

	assign o_frozen = frozen;

	// RQ9 only sleep setting discards SRAM on wake
	assign sram_clear = frozen & wake & ~suspend;
	assign sram_we = wr_go && !frozen && (i_avs_address == fmw_pkg::ADDR_SRAM_DATA)
		&& (i_avs_byteenable == 4'hF);

	fmw_sram u_sram (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_we    (sram_we),
		.i_addr  (sram_addr),
		.i_wdata (i_avs_writedata),
		.i_clear (sram_clear),
		.o_rdata (sram_rdata)
	);

	property p_halt;
		@(posedge i_clk) disable iff (i_rst)
		frozen |=> (o_count == $past(o_count));
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while frozen"); // RQ1

	property p_edge_wake;
		@(posedge i_clk) disable iff (i_rst)
		(frozen && |(edge_m & (lvl ^ snap))) |=> !frozen;
	endproperty
	a_edge_wake: assert property (p_edge_wake) else $error("edge pin did not wake"); // RQ2

	property p_and;
		@(posedge i_clk) disable iff (i_rst)
		(frozen && !edge_hit && (|(hi_m & ~lvl) || |(lo_m & lvl))) |=> frozen;
	endproperty
	a_and: assert property (p_and) else $error("woke on partial signature"); // RQ5

	property p_sig_wake;
		@(posedge i_clk) disable iff (i_rst)
		(frozen && sig_match) |=> !frozen;
	endproperty
	a_sig_wake: assert property (p_sig_wake) else $error("signature did not wake"); // RQ6

	property p_stay;
		@(posedge i_clk) disable iff (i_rst)
		(!frozen && sig_match) |=> !frozen;
	endproperty
	a_stay: assert property (p_stay) else $error("froze during signature"); // RQ7

	property p_resume;
		@(posedge i_clk) disable iff (i_rst)
		$fell(frozen) |-> ##1 (o_count == $past(o_count, 2) + 1'b1);
	endproperty
	a_resume: assert property (p_resume) else $error("counter lost state on wake"); // RQ8

	property p_suspend;
		@(posedge i_clk) disable iff (i_rst)
		(frozen && suspend) |=> (sram_rdata == $past(sram_rdata)) || $changed(sram_addr);
	endproperty
	a_suspend: assert property (p_suspend) else $error("SRAM cleared in suspend"); // RQ9

	property p_idle_pin;
		@(posedge i_clk) disable iff (i_rst)
		(frozen && $past(frozen)) |-> (o_pin_oe == $past(held_oe & hold))
			&& (o_pin_out == $past(held_out & hold));
	endproperty
	a_idle_pin: assert property (p_idle_pin) else $error("pin not tristated or held"); // RQ11

	property p_no_out_role;
		@(posedge i_clk) disable iff (i_rst)
		((edge_m | hi_m | lo_m) & ~fmw_pkg::PIN_WAKE_CAPABLE) == '0;
	endproperty
	a_no_out_role: assert property (p_no_out_role) else $error("output pin has role"); // RQ12

	property p_debounce;
		@(posedge i_clk) disable iff (i_rst)
		$changed(deb[0]) |-> ($past(deb_cnt[0]) == fmw_pkg::DEB_LAST);
	endproperty
	a_debounce: assert property (p_debounce) else $error("input passed unsettled"); // RQ13
endmodule // fmw_ctrl

// file: verif/fmw_pins.sv
`timescale 1ns/1ns
module fmw_pins (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_want_wake,
	input  wire logic       i_want_entry,
	input  wire logic       i_bounce,
	output logic      [7:0] o_wake_pin,
	output logic            o_freeze_entry_request
);
	logic [7:0] last;
	logic [1:0] glitch;

	initial begin
		o_wake_pin = 8'h00;
		o_freeze_entry_request = 1'b0;
		last = 8'h00;
		glitch = 2'h0;
	end

	// pins follow the bench
	// Switch contacts chatter for one cycle before settling when asked
	always @(posedge i_clk) begin
		o_freeze_entry_request <= i_want_entry;
		if (i_want_wake != last && i_bounce) begin
			glitch <= 2'h2;
		end else if (glitch != 2'h0) begin
			glitch <= glitch - 2'h1;
		end
		last <= i_want_wake;
		o_wake_pin <= (glitch == 2'h1) ? ~i_want_wake : i_want_wake;
	end
endmodule // fmw_pins

// file: verif/freeze_mode_wake_control_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module freeze_mode_wake_control_tb;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        waitreq;
	logic [7:0]  want_wake = 8'h00;
	logic        want_entry = 1'b0;
	logic [7:0]  wake_pin;
	logic        entry_pin;
	logic [7:0]  fab_out = 8'h00;
	logic [7:0]  pin_out, pin_oe;
	logic        frozen;
	logic [15:0] count, c0;
	logic [15:0] lfsr = 16'h28B7;
	logic [31:0] q;
	logic [31:0] mem [4];
	int          fail_count = 0;
	int          checked = 0;
	int          cyc = 0;

	fmw_ctrl uut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_wake_pin(wake_pin),
		.i_freeze_entry_request(entry_pin), .i_fab_out(fab_out), .i_fab_oe(8'hFF),
		.o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_frozen(frozen), .o_count(count));

	fmw_pins pins (.i_clk(i_clk), .i_want_wake(want_wake), .i_want_entry(want_entry),
		.i_bounce(lfsr[0]), .o_wake_pin(wake_pin), .o_freeze_entry_request(entry_pin));

	always #20 i_clk = ~i_clk;

	function automatic logic [15:0] lfsr_next(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// Fabric drive changes every cycle so a missed freeze shows on the pins
	always @(posedge i_clk) begin
		lfsr <= lfsr_next(lfsr);
		fab_out <= lfsr[7:0];
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks=%0d fails=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= ~w;
		do @(posedge i_clk); while (waitreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic wait_frozen(input logic v);
		int n;
		n = 0;
		while (frozen !== v && n < 4000) begin
			@(posedge i_clk);
			n++;
		end
	endtask

	// Wake pins pass the debounce before the next step
	task automatic settle();
		repeat (2700) @(posedge i_clk);
	endtask

	task automatic check_frozen_quiet();
		logic [7:0] held;
		c0 = count;
		// Pins take their frozen drive one edge after the state flips
		@(posedge i_clk);
		held = pin_out;
		repeat (20) @(posedge i_clk);
		`CHK(count, c0)
		`CHK(pin_out, held)
		`CHK(pin_out & 8'hF0, 8'h00)
		`CHK(pin_oe, 8'h0F)
	endtask

	task automatic check_resumed(input logic [31:0] keep);
		repeat (5) @(posedge i_clk);
		`CHK(count > c0, 1'b1)
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, fmw_pkg::ADDR_SRAM_ADDR, 32'(i * 5));
			bus(1'b0, fmw_pkg::ADDR_SRAM_DATA, 32'h0);
			`CHK(q, mem[i] & keep)
		end
	endtask

	initial begin
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		bus(1'b0, fmw_pkg::ADDR_ROLE, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b0, 8'h1C, 32'h0);
		`CHK(q, 32'h0)
		bus(1'b1, fmw_pkg::ADDR_ROLE, 32'hFFFF);
		bus(1'b0, fmw_pkg::ADDR_ROLE, 32'h0);
		`CHK(q, 32'h0FFF)
		// Pin 0 any edge, pin 1 wake on high, pin 2 wake on low
		bus(1'b1, fmw_pkg::ADDR_ROLE, 32'h0039);
		bus(1'b1, fmw_pkg::ADDR_HOLD, 32'h0F);
		for (int i = 0; i < 4; i++) begin
			mem[i] = {lfsr, lfsr_next(lfsr)};
			bus(1'b1, fmw_pkg::ADDR_SRAM_ADDR, 32'(i * 5));
			bus(1'b1, fmw_pkg::ADDR_SRAM_DATA, mem[i]);
		end
		bus(1'b1, fmw_pkg::ADDR_CTRL, 32'h3);
		wait_frozen(1'b1);
		`CHK(frozen, 1'b1)
		check_frozen_quiet();
		want_wake <= 8'h01;
		wait_frozen(1'b0);
		`CHK(frozen, 1'b0)
		check_resumed(32'hFFFFFFFF);
		want_entry <= 1'b1;
		wait_frozen(1'b1);
		`CHK(frozen, 1'b1)
		want_entry <= 1'b0;
		check_frozen_quiet();
		want_wake <= 8'h00;
		wait_frozen(1'b0);
		`CHK(frozen, 1'b0)
		bus(1'b1, fmw_pkg::ADDR_CTRL, 32'h3);
		wait_frozen(1'b1);
		want_wake <= 8'h06;
		settle();
		`CHK(frozen, 1'b1)
		want_wake <= 8'h02;
		wait_frozen(1'b0);
		`CHK(frozen, 1'b0)
		settle();
		bus(1'b0, fmw_pkg::ADDR_STATUS, 32'h0);
		`CHK(q[15:0], 16'h0202)
		bus(1'b1, fmw_pkg::ADDR_CTRL, 32'h3);
		repeat (10) @(posedge i_clk);
		`CHK(frozen, 1'b0)
		want_wake <= 8'h00;
		settle();
		bus(1'b1, fmw_pkg::ADDR_CTRL, 32'h1);
		wait_frozen(1'b1);
		`CHK(frozen, 1'b1)
		want_wake <= 8'h01;
		wait_frozen(1'b0);
		`CHK(frozen, 1'b0)
		check_resumed(32'h0);
		final_report();
	end
endmodule // freeze_mode_wake_control_tb
